/* rtl/gpt_timer_pair.sv */
`timescale 1ns/10ps
// How it works
// - Two 16-bit counters, or one 32-bit
// - ADC triggers of all timers ORed
// - Reset: idle, counters and loads all ones
// - Prescaler only for individual counters
// - Counters only ever count down
// - Chained: counter A controls alone
// - Prescaler widens 16-bit range to 32 bits
// - Reload from load value after zero
// - One-shot stops, periodic keeps counting
// - Zero sets sticky timeout flag
// - New load taken at once; prescale at wrap, or next cycle if below count
// - Debug stall freezes counter while halted
// - Prescaler divides by value plus one
// - No prescaler in edge count mode
// - Edge count: mode 3, count mode clear
// - Each selected edge decrements by one
// - Match sets raw and masked flag
// - Match reloads, disables, ignores edges
// - All functions chosen by registers
// - Edge select 3 means both edges
// - Unmask, mask writes; mask view readable
module gpt_timer_pair (
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// System
	input  wire logic        dbg_halt,      // Processor halted by debugger
	input  wire logic [1:0]  capture_pin,   // Edge inputs, A in bit 0
	input  wire logic        adc_trig_in,   // Triggers of the other timers
	output logic             adc_trig,      // Combined ADC trigger
	output logic             irq            // Interrupt request
);

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic [1:0] rs_r;    // Reset release synchroniser
	logic       rstn_s;  // Synchronised reset

	// Release reset two clocks after rstn rises
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rs_r <= 2'h0;
		else
			rs_r <= {rs_r[0], 1'b1};
	end

	assign rstn_s = rs_r[1];

	// ****************************************************************
	// Registers and state
	// ****************************************************************
	logic                  cfg_split_r;   // Width config: 1 individual
	gpt_pkg::gpt_chctl_t   ctl_r[2];      // Control per counter
	gpt_pkg::gpt_mode_t    mode_r[2];     // Mode per counter
	logic [15:0]           ilr_r[2];      // Interval load values
	logic [15:0]           mt_r[2];       // Match values
	logic [15:0]           pv_r[2];       // Prescale values
	logic [15:0]           cnt_r[2];      // Counters
	logic [15:0]           cnt_nxt[2];    // Next counter values
	logic [gpt_pkg::GPT_NFLAG-1:0] imr_r; // Mask view, 1 = enabled
	logic [gpt_pkg::GPT_NFLAG-1:0] ris_r; // Raw flags
	logic [gpt_pkg::GPT_NFLAG-1:0] flag_set; // Flag set events
	logic [31:0]           prdata_r;      // Read data
	logic                  adc_r;         // ADC trigger
	logic                  irq_r;         // Interrupt
	logic [31:0]           rd_data;       // Read mux
	logic                  rd_hit;        // Mapped address

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic       wr;       // Write access phase
	logic       cfg_we;   // Width config write
	logic       ctl_we;   // Control write
	logic       ier_we;   // Unmask write
	logic       idr_we;   // Mask write
	logic       isc_we;   // Flag clear write
	logic [1:0] mode_we;  // Mode writes
	logic [1:0] ilr_we;   // Load value writes
	logic [1:0] mt_we;    // Match writes
	logic [1:0] pre_we;   // Prescale writes

	assign wr     = psel & penable & pwrite;
	assign cfg_we = wr & (paddr == gpt_pkg::GPT_OFS_CFG);
	assign ctl_we = wr & (paddr == gpt_pkg::GPT_OFS_CTL);
	assign ier_we = wr & (paddr == gpt_pkg::GPT_OFS_IER);
	assign idr_we = wr & (paddr == gpt_pkg::GPT_OFS_IDR);
	assign isc_we = wr & (paddr == gpt_pkg::GPT_OFS_ISC);

	// ****************************************************************
	// Per-counter decode and mode
	// ****************************************************************
	logic [1:0] ch_run;   // Counter enabled and not stalled
	logic [1:0] edge_md;  // Edge count mode
	logic [1:0] tmr_md;   // One-shot or periodic
	logic [1:0] one_md;   // One-shot
	logic [1:0] tick;     // Count this cycle

	for (genvar i = 0; i < 2; i++)
	begin : g_ch
		assign mode_we[i] = wr & (paddr == gpt_pkg::GPT_OFS_MODE[i]);
		assign ilr_we[i]  = wr & (paddr == gpt_pkg::GPT_OFS_ILR[i]);
		assign mt_we[i]   = wr & (paddr == gpt_pkg::GPT_OFS_MATCH[i]);
		assign pre_we[i]  = wr & (paddr == gpt_pkg::GPT_OFS_PRE[i]);

		// Counter B is idle when chained
		assign ch_run[i] = ctl_r[i].counter_run_enable
		                   & ~(ctl_r[i].debug_stall_enable & dbg_halt)
		                   & (cfg_split_r | (i == 0));
		assign edge_md[i] = cfg_split_r & (mode_r[i].mode == gpt_pkg::GPT_MD_EDGE)
		                    & ~mode_r[i].count_mode_select;
		assign one_md[i]  = (mode_r[i].mode == gpt_pkg::GPT_MD_ONESHOT);
		assign tmr_md[i]  = one_md[i] | (mode_r[i].mode == gpt_pkg::GPT_MD_PERIODIC);

		// Count enable source; prescaler off when chained
		gpt_tick #(
			.PW (16)
		) u_tick (
			.clk       (clk),
			.rstn      (rstn_s),
			.pin       (capture_pin[i]),
			.run       (ch_run[i]),
			.edge_mode (edge_md[i]),
			.evt       (ctl_r[i].edge_event_select),
			.pre_on    (cfg_split_r),
			.pv        (pv_r[i]),
			.tick      (tick[i])
		);
	end

	// ****************************************************************
	// Counter next state
	// ****************************************************************
	logic [31:0] c32;      // Chained count
	logic [31:0] c32_dec;  // Chained count less one
	logic [1:0]  to_set;   // Timeout events
	logic [1:0]  mt_set;   // Match events
	logic [1:0]  en_clr;   // Hardware clears run enable

	assign c32     = {cnt_r[1], cnt_r[0]};
	assign c32_dec = c32 - 32'h1;

	// Down-count, reload and stop decisions
	always_comb
	begin
		to_set = 2'h0;
		mt_set = 2'h0;
		en_clr = 2'h0;
		for (int i = 0; i < 2; i++)
			cnt_nxt[i] = cnt_r[i];
		if (!cfg_split_r)
		begin
			// One 32-bit counter under counter A control
			if (ch_run[0] && tmr_md[0])
			begin
				if (c32 == 32'h0)
				begin
					{cnt_nxt[1], cnt_nxt[0]} = {ilr_r[1], ilr_r[0]};
					en_clr[0] = one_md[0];
				end
				else
				begin
					{cnt_nxt[1], cnt_nxt[0]} = c32_dec;
					to_set[0] = (c32_dec == 32'h0);
				end
			end
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (ch_run[i] && tick[i] && edge_md[i])
				begin
					// Edge count: stop at match
					if ((cnt_r[i] - 16'h1) == mt_r[i])
					begin
						cnt_nxt[i] = ilr_r[i];
						mt_set[i]  = 1'b1;
						en_clr[i]  = 1'b1;
					end
					else
						cnt_nxt[i] = cnt_r[i] - 16'h1;
				end
				else if (ch_run[i] && tick[i] && tmr_md[i])
				begin
					if (cnt_r[i] == 16'h0)
					begin
						cnt_nxt[i] = ilr_r[i];
						en_clr[i]  = one_md[i];
					end
					else
					begin
						cnt_nxt[i] = cnt_r[i] - 16'h1;
						to_set[i]  = (cnt_r[i] == 16'h1);
					end
				end
			end
		end
		// A new load value is taken at once
		for (int i = 0; i < 2; i++)
			if (ilr_we[i])
				cnt_nxt[i] = pwdata[15:0];
	end

	// Gather flag events
	for (genvar i = 0; i < 2; i++)
	begin : g_flag
		assign flag_set[2*i+gpt_pkg::GPT_FLAG_TO] = to_set[i];
		assign flag_set[2*i+gpt_pkg::GPT_FLAG_MT] = mt_set[i];
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rstn_s)
	begin
		if (!rstn_s)
		begin
			cfg_split_r <= 1'b0;
			for (int i = 0; i < 2; i++)
			begin
				ctl_r[i]  <= '0;
				mode_r[i] <= '0;
				ilr_r[i]  <= gpt_pkg::GPT_ILR_RST;
				mt_r[i]   <= 16'h0;
				pv_r[i]   <= 16'h0;
			end
		end
		else
		begin
			if (cfg_we)
				cfg_split_r <= pwdata[gpt_pkg::GPT_CFG_SPLIT_POS];
			for (int i = 0; i < 2; i++)
			begin
				// Software write wins over the hardware clear
				if (ctl_we)
					ctl_r[i] <= pwdata[gpt_pkg::GPT_CTL_STRIDE*i +: 5];
				else if (en_clr[i])
					ctl_r[i].counter_run_enable <= 1'b0;
				if (mode_we[i])
					mode_r[i] <= pwdata[2:0];
				if (ilr_we[i])
					ilr_r[i] <= pwdata[15:0];
				if (mt_we[i])
					mt_r[i] <= pwdata[15:0];
				if (pre_we[i])
					pv_r[i] <= pwdata[15:0];
			end
		end
	end

	// ****************************************************************
	// Counters, flags and outputs
	// ****************************************************************
	always_ff @(posedge clk or negedge rstn_s)
	begin
		if (!rstn_s)
		begin
			for (int i = 0; i < 2; i++)
				cnt_r[i] <= gpt_pkg::GPT_CNT_RST;
			imr_r <= '0;
			ris_r <= '0;
			adc_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
				cnt_r[i] <= cnt_nxt[i];
			if (ier_we)
				imr_r <= imr_r | pwdata[gpt_pkg::GPT_NFLAG-1:0];
			else if (idr_we)
				imr_r <= imr_r & ~pwdata[gpt_pkg::GPT_NFLAG-1:0];
			// Set wins over clear
			ris_r <= (ris_r & ~({gpt_pkg::GPT_NFLAG{isc_we}} & pwdata[3:0]))
			         | flag_set;
			adc_r <= (to_set[0] & ctl_r[0].adc_en) | (to_set[1] & ctl_r[1].adc_en)
			         | adc_trig_in;
			irq_r <= |(ris_r & imr_r);
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	always_comb
	begin
		rd_data = 32'h0;
		rd_hit  = 1'b1;
		case (paddr)
			gpt_pkg::GPT_OFS_CFG:      rd_data = {31'h0, cfg_split_r};
			gpt_pkg::GPT_OFS_CTL:      rd_data = {19'h0, ctl_r[1], 3'h0, ctl_r[0]};
			gpt_pkg::GPT_OFS_MODE[0]:  rd_data = {29'h0, mode_r[0]};
			gpt_pkg::GPT_OFS_MODE[1]:  rd_data = {29'h0, mode_r[1]};
			gpt_pkg::GPT_OFS_ILR[0]:   rd_data = {16'h0, ilr_r[0]};
			gpt_pkg::GPT_OFS_ILR[1]:   rd_data = {16'h0, ilr_r[1]};
			gpt_pkg::GPT_OFS_MATCH[0]: rd_data = {16'h0, mt_r[0]};
			gpt_pkg::GPT_OFS_MATCH[1]: rd_data = {16'h0, mt_r[1]};
			gpt_pkg::GPT_OFS_PRE[0]:   rd_data = {16'h0, pv_r[0]};
			gpt_pkg::GPT_OFS_PRE[1]:   rd_data = {16'h0, pv_r[1]};
			gpt_pkg::GPT_OFS_IER:      rd_data = 32'h0;
			gpt_pkg::GPT_OFS_IDR:      rd_data = 32'h0;
			gpt_pkg::GPT_OFS_IMR:      rd_data = {28'h0, imr_r};
			gpt_pkg::GPT_OFS_RIS:      rd_data = {28'h0, ris_r};
			gpt_pkg::GPT_OFS_ISC:      rd_data = {28'h0, ris_r & imr_r};
			gpt_pkg::GPT_OFS_CNT[0]:   rd_data = {16'h0, cnt_r[0]};
			gpt_pkg::GPT_OFS_CNT[1]:   rd_data = {16'h0, cnt_r[1]};
			default:                   rd_hit  = 1'b0;
		endcase
	end

	// Read data captured in the setup phase
	always_ff @(posedge clk or negedge rstn_s)
	begin
		if (!rstn_s)
			prdata_r <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata_r <= rd_data;
	end

	assign prdata   = prdata_r;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~rd_hit;
	assign adc_trig = adc_r;
	assign irq      = irq_r;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn_s);

	property p_rst_cnt;
		$rose(rstn_s) |-> cnt_r[0] == 16'hFFFF && cnt_r[1] == 16'hFFFF && !ctl_r[0].counter_run_enable;
	endproperty
	a_rst_cnt: assert property (p_rst_cnt) else $error("counters not all ones after reset");

	property p_down;
		cfg_split_r && !ilr_we[0] && !edge_md[0] && cnt_r[0] != 16'h0
		|=> cnt_r[0] == $past(cnt_r[0]) || cnt_r[0] == $past(cnt_r[0]) - 16'h1;
	endproperty
	a_down: assert property (p_down) else $error("counter A moved other than down by one");

	property p_reload;
		cfg_split_r && ch_run[0] && tmr_md[0] && tick[0] && cnt_r[0] == 16'h0 && !ilr_we[0]
		|=> cnt_r[0] == $past(ilr_r[0]);
	endproperty
	a_reload: assert property (p_reload) else $error("counter A did not reload at zero");

	property p_oneshot;
		cfg_split_r && ch_run[0] && one_md[0] && tick[0] && cnt_r[0] == 16'h0 && !ctl_we
		|=> !ctl_r[0].counter_run_enable;
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");

	property p_to_flag;
		to_set[0] |=> ris_r[gpt_pkg::GPT_FLAG_TO] ##1 ris_r[gpt_pkg::GPT_FLAG_TO] || $past(isc_we);
	endproperty
	a_to_flag: assert property (p_to_flag) else $error("timeout flag not set");

	property p_flag_hold;
		ris_r[0] && !(isc_we && pwdata[0]) |=> ris_r[0];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("timeout flag dropped");

	property p_stall;
		ctl_r[0].debug_stall_enable && dbg_halt && !ilr_we[0]
		|=> $stable(cnt_r[0]);
	endproperty
	a_stall: assert property (p_stall) else $error("counter A moved while stalled");

	property p_edge_stop;
		mt_set[0] && !ctl_we && !ilr_we[0]
		|=> !ctl_r[0].counter_run_enable && cnt_r[0] == $past(ilr_r[0])
		&& ris_r[gpt_pkg::GPT_FLAG_MT];
	endproperty
	a_edge_stop: assert property (p_edge_stop) else $error("match did not reload and stop");

	property p_mask;
		ier_we && pwdata[1] |=> imr_r[1];
	endproperty
	a_mask: assert property (p_mask) else $error("unmask write not taken");

	property p_adc;
		adc_trig_in |=> adc_trig;
	endproperty
	a_adc: assert property (p_adc) else $error("ADC trigger not combined");

	property p_irq;
		(ris_r & imr_r) != 4'h0 |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule // gpt_timer_pair

/* rtl/gpt_pkg.sv */
// ****************************************************************
// Shared constants and types of the timer pair
// ****************************************************************
package gpt_pkg;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] GPT_OFS_CFG     = 8'h00;
	localparam logic [7:0] GPT_OFS_CTL     = 8'h04;
	localparam logic [7:0] GPT_OFS_MODE[2] = '{8'h08, 8'h0C};
	localparam logic [7:0] GPT_OFS_ILR[2]  = '{8'h10, 8'h14};
	localparam logic [7:0] GPT_OFS_MATCH[2] = '{8'h18, 8'h1C};
	localparam logic [7:0] GPT_OFS_PRE[2]  = '{8'h20, 8'h24};
	localparam logic [7:0] GPT_OFS_IER     = 8'h28;
	localparam logic [7:0] GPT_OFS_IDR     = 8'h2C;
	localparam logic [7:0] GPT_OFS_IMR     = 8'h30;
	localparam logic [7:0] GPT_OFS_RIS     = 8'h34;
	localparam logic [7:0] GPT_OFS_ISC     = 8'h38;
	localparam logic [7:0] GPT_OFS_CNT[2]  = '{8'h3C, 8'h40};

	// Field positions
	localparam int GPT_CFG_SPLIT_POS = 0;   // 1: two 16-bit counters, 0: one 32-bit
	localparam int GPT_CTL_STRIDE    = 8;   // Counter B control sits 8 bits up
	localparam int GPT_FLAG_TO       = 0;   // Timeout flag, index 2*n+0
	localparam int GPT_FLAG_MT       = 1;   // Match flag, index 2*n+1
	localparam int GPT_NFLAG         = 4;   // Flags in the status registers

	// Reset values
	localparam logic [15:0] GPT_CNT_RST = 16'hFFFF;
	localparam logic [15:0] GPT_ILR_RST = 16'hFFFF;
	localparam logic [15:0] GPT_PRE_RST = 16'hFFFF;

	// Mode field codes
	localparam logic [1:0] GPT_MD_ONESHOT  = 2'h1;
	localparam logic [1:0] GPT_MD_PERIODIC = 2'h2;
	localparam logic [1:0] GPT_MD_EDGE     = 2'h3;

	// Edge select codes
	localparam logic [1:0] GPT_EVT_RISE = 2'h0;
	localparam logic [1:0] GPT_EVT_FALL = 2'h1;
	localparam logic [1:0] GPT_EVT_BOTH = 2'h3;

	// Per-counter control bits
	typedef struct packed {
		logic       adc_en;        // Timeout drives the ADC trigger
		logic       debug_stall_enable;
		logic [1:0] edge_event_select;
		logic       counter_run_enable;
	} gpt_chctl_t;

	// Per-counter mode register
	typedef struct packed {
		logic       count_mode_select;
		logic [1:0] mode;
	} gpt_mode_t;

endpackage

/* rtl/gpt_tick.sv */
`timescale 1ns/10ps
// ****************************************************************
// Count enable source: prescaler or capture pin edge
// ****************************************************************
module gpt_tick #(
	parameter int PW = 16                  // Prescaler width
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          pin,        // Capture pin, asynchronous
	input  wire logic          run,        // Counter running
	input  wire logic          edge_mode,  // Count pin edges
	input  wire logic [1:0]    evt,        // Edge select
	input  wire logic          pre_on,     // Prescaler in use
	input  wire logic [PW-1:0] pv,         // Prescale value
	output logic               tick        // Count this cycle
);

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (PW < 2 || PW > 16)
	begin : g_bad_pw
		$error("gpt_tick: PW must lie in 2..16");
	end

	logic [2:0]    sync_r;   // Two-flop synchroniser plus history
	logic [PW-1:0] pre_r;    // Prescaler down-counter
	logic          rise;     // Rising edge seen
	logic          fall;     // Falling edge seen
	logic          edge_hit; // Selected edge seen
	logic          pre_hit;  // Prescaler wrapped

	// Pin synchroniser; stage 0 feeds only stage 1
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sync_r <= 3'h0;
		else
			sync_r <= {sync_r[1:0], pin};
	end

	// Edge detect on synchronised samples
	assign rise     = sync_r[1] & ~sync_r[2];
	assign fall     = ~sync_r[1] & sync_r[2];
	assign edge_hit = (evt == gpt_pkg::GPT_EVT_BOTH) ? (rise | fall) :
	                  (evt == gpt_pkg::GPT_EVT_FALL) ? fall : rise;

	// Prescaler counts pv..0, giving a ratio of pv+1
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pre_r <= PW'(gpt_pkg::GPT_PRE_RST);
		else if (!run || !pre_on || pre_r == '0 || pre_r > pv)
			pre_r <= pv;
		else
			pre_r <= pre_r - PW'(1);
	end

	assign pre_hit = (pre_r == '0);

	// Edge mode ignores the prescaler
	assign tick = edge_mode ? edge_hit : (pre_on ? pre_hit : 1'b1);

endmodule // gpt_tick

/* dv/gpt_edge_src.sv */
`timescale 1ns/10ps
// ****************************************************************
// Capture pin source: toggles the pin n times on request
// ****************************************************************
module gpt_edge_src (
	input  wire logic       clk,
	input  wire logic       go,    // Start a burst
	input  wire logic [7:0] n,     // Number of edges
	output logic            pin,   // Capture pin level
	output logic            busy   // Burst under way
);
	// Idle low, nothing pending
	initial
	begin
		pin = 1'b0;
		busy = 1'b0;
	end
	// Each level stands four clocks, then a tail for the synchroniser
	always
	begin
		do @(posedge clk); while (go !== 1'b1);
		busy <= 1'b1;
		repeat (n)
		begin
			repeat (4) @(posedge clk);
			pin <= ~pin;
		end
		repeat (8) @(posedge clk);
		busy <= 1'b0;
	end
endmodule // gpt_edge_src

/* dv/gpt_timer_pair_bench.sv */
`timescale 1ns/10ps
module gpt_timer_pair_bench;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        dbg_halt, adc_trig_in, adc_trig, irq, pin, go, busy, err;
	logic [7:0]  n_edges;
	int          n_errors = 0;
	int          check_count = 0;
	int          per;

	gpt_timer_pair i_gpt_timer_pair (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt),
		.capture_pin({1'b0, pin}), .adc_trig_in(adc_trig_in),
		.adc_trig(adc_trig), .irq(irq));
	gpt_edge_src i_gpt_edge_src (.clk(clk), .go(go), .n(n_edges), .pin(pin), .busy(busy));

	// Clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ****************************************************************
	// Bus and check tasks
	// ****************************************************************
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Read until a bit shows, bounded
	task automatic poll(input logic [7:0] a, input logic [31:0] m);
		int k;
		k = 0;
		do
		begin
			apb(1'b0, a, 32'h0);
			k++;
		end
		while ((rd & m) === 32'h0 && k < 100);
		chk(rd & m, m);
	endtask
	// Cycles up to the next trigger pulse
	task automatic wait_trig();
		per = 0;
		do
		begin
			@(posedge clk);
			per++;
		end
		while (adc_trig !== 1'b1 && per < 400);
	endtask
	task automatic burst(input logic [7:0] k);
		go <= 1'b1;
		n_edges <= k;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy === 1'b1) @(posedge clk);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		for (int i = 0; i < 2; i++)
		begin
			rdc(gpt_pkg::GPT_OFS_CNT[i], 32'h0000FFFF);
			rdc(gpt_pkg::GPT_OFS_ILR[i], 32'h0000FFFF);
		end
		rdc(gpt_pkg::GPT_OFS_CTL, 32'h0);
		rdc(gpt_pkg::GPT_OFS_CFG, 32'h0);
		apb(1'b0, 8'hF0, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("reset and unmapped done");
	endtask
	task automatic t_oneshot();
		wr(gpt_pkg::GPT_OFS_CFG, 32'h1);
		wr(gpt_pkg::GPT_OFS_MODE[0], 32'h1);
		wr(gpt_pkg::GPT_OFS_ILR[0], 32'h3);
		wr(gpt_pkg::GPT_OFS_IER, 32'h1);
		wr(gpt_pkg::GPT_OFS_CTL, 32'h1);
		poll(gpt_pkg::GPT_OFS_RIS, 32'h1);
		rdc(gpt_pkg::GPT_OFS_CTL, 32'h0);
		rdc(gpt_pkg::GPT_OFS_CNT[0], 32'h3);
		chk({31'h0, irq}, 32'h1);
		rdc(gpt_pkg::GPT_OFS_ISC, 32'h1);
		wr(gpt_pkg::GPT_OFS_ISC, 32'h1);
		rdc(gpt_pkg::GPT_OFS_RIS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(gpt_pkg::GPT_OFS_IDR, 32'h1);
		rdc(gpt_pkg::GPT_OFS_IMR, 32'h0);
		$display("one-shot done");
	endtask
	task automatic t_periodic();
		wr(gpt_pkg::GPT_OFS_MODE[1], 32'h2);
		wr(gpt_pkg::GPT_OFS_PRE[1], 32'h1);
		wr(gpt_pkg::GPT_OFS_ILR[1], 32'h4);
		wr(gpt_pkg::GPT_OFS_CTL, 32'h1100);
		wait_trig();
		wait_trig();
		chk(per, 10);
		rdc(gpt_pkg::GPT_OFS_CTL, 32'h1100);
		wr(gpt_pkg::GPT_OFS_PRE[1], 32'h0);
		wait_trig();
		wait_trig();
		chk(per, 5);
		wr(gpt_pkg::GPT_OFS_CTL, 32'h0);
		$display("periodic done");
	endtask
	task automatic t_chained();
		logic [31:0] v;
		wr(gpt_pkg::GPT_OFS_CFG, 32'h0);
		wr(gpt_pkg::GPT_OFS_MODE[0], 32'h2);
		wr(gpt_pkg::GPT_OFS_PRE[0], 32'h3);
		wr(gpt_pkg::GPT_OFS_ILR[1], 32'h0);
		wr(gpt_pkg::GPT_OFS_ILR[0], 32'h4);
		wr(gpt_pkg::GPT_OFS_CTL, 32'h19);
		wait_trig();
		wait_trig();
		chk(per, 5);
		dbg_halt <= 1'b1;
		apb(1'b0, gpt_pkg::GPT_OFS_CNT[0], 32'h0);
		v = rd;
		rdc(gpt_pkg::GPT_OFS_CNT[0], v);
		dbg_halt <= 1'b0;
		apb(1'b0, gpt_pkg::GPT_OFS_CNT[0], 32'h0);
		chk(32'(rd !== v), 32'h1);
		wr(gpt_pkg::GPT_OFS_CTL, 32'h0);
		$display("chained and stall done");
	endtask
	task automatic t_edges();
		logic [1:0] ev[3] = '{2'h0, 2'h1, 2'h3};
		int dec[3] = '{2, 2, 4};
		wr(gpt_pkg::GPT_OFS_CFG, 32'h1);
		wr(gpt_pkg::GPT_OFS_MODE[0], 32'h3);
		wr(gpt_pkg::GPT_OFS_MATCH[0], 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			wr(gpt_pkg::GPT_OFS_ILR[0], 32'hA);
			wr(gpt_pkg::GPT_OFS_CTL, {29'h0, ev[i], 1'b1});
			burst(8'h4);
			rdc(gpt_pkg::GPT_OFS_CNT[0], 32'hA - 32'(dec[i]));
			wr(gpt_pkg::GPT_OFS_CTL, 32'h0);
		end
		// Count mode bit set: not edge count, edges leave the counter alone
		wr(gpt_pkg::GPT_OFS_MODE[0], 32'h7);
		wr(gpt_pkg::GPT_OFS_ILR[0], 32'hA);
		wr(gpt_pkg::GPT_OFS_CTL, 32'h1);
		burst(8'h2);
		rdc(gpt_pkg::GPT_OFS_CNT[0], 32'hA);
		wr(gpt_pkg::GPT_OFS_CTL, 32'h0);
		wr(gpt_pkg::GPT_OFS_MODE[0], 32'h3);
		// Load 0xA, match 6: four edges counted, the last two ignored
		wr(gpt_pkg::GPT_OFS_ISC, 32'hF);
		wr(gpt_pkg::GPT_OFS_IER, 32'h2);
		wr(gpt_pkg::GPT_OFS_MATCH[0], 32'h6);
		wr(gpt_pkg::GPT_OFS_CTL, 32'h7);
		burst(8'h6);
		rdc(gpt_pkg::GPT_OFS_RIS, 32'h2);
		rdc(gpt_pkg::GPT_OFS_ISC, 32'h2);
		chk({31'h0, irq}, 32'h1);
		rdc(gpt_pkg::GPT_OFS_CTL, 32'h6);
		rdc(gpt_pkg::GPT_OFS_CNT[0], 32'hA);
		$display("edge count done");
	endtask
	task automatic t_adc_in();
		@(posedge clk);
		adc_trig_in <= 1'b1;
		@(posedge clk);
		adc_trig_in <= 1'b0;
		wait_trig();
		chk(32'(per <= 2), 32'h1);
		$display("trigger merge done");
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{rstn, psel, penable, pwrite, dbg_halt, adc_trig_in, go} = 7'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		n_edges = 8'h0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_oneshot();
		t_periodic();
		t_chained();
		t_edges();
		t_adc_in();
		tally_and_finish();
	end
	// Watchdog
	initial
	begin
		#(50 * 60000);
		n_errors++;
		tally_and_finish();
	end
endmodule // gpt_timer_pair_bench
